// [core/port_wred_egress_queue_config.sv]
`timescale 1ns/1ps
// Overview of operation
// - memory-level probability multiplier, bits 26:16, reset 0x020
// - per-queue max/min thresholds, reset 0x080 and 0x009
// - per-queue probability multiplier, reset 0x010
// - read-only queue and memory average sizes
// - bit 31 enables random dropping
// - flush counters on rising edge of bit 30
// - bits 29..27 protect colours from dropping
// - bit 26 drops all above maximum
// - read-only 24-bit event count per queue
// - 2-bit queue index selects indexed registers
// - index also writable as byte 0x903
// - replace nonzero egress VLAN ID with default
// - scheduler mode only for 2 or 4 queues
// - strict priority serves highest queue first
// - round robin serves queues in turn
// - shaper mode selects none, credit, time-aware
// - 7-bit weight limits packets per turn
// - memory-level thresholds, reset 0x400 and 0x080
module port_wred_egress_queue_config
   import wred_egress_pkg::*;
(
   // clock and reset
   input  logic        clk_in,
   input  logic        rst_n_in,
   // axi4-lite write
   input  logic [11:0] awaddr_in,
   input  logic [2:0]  awprot_in,
   input  logic        awvalid_in,
   output logic        awready_out,
   input  logic [31:0] wdata_in,
   input  logic [3:0]  wstrb_in,
   input  logic        wvalid_in,
   output logic        wready_out,
   output logic [1:0]  bresp_out,
   output logic        bvalid_out,
   input  logic        bready_in,
   // axi4-lite read
   input  logic [11:0] araddr_in,
   input  logic [2:0]  arprot_in,
   input  logic        arvalid_in,
   output logic        arready_out,
   output logic [31:0] rdata_out,
   output logic [1:0]  rresp_out,
   output logic        rvalid_out,
   input  logic        rready_in,
   // queue measurement
   input  logic [10:0] mem_avg_in,
   input  logic [43:0] q_avg_in,
   input  logic [3:0]  pkt_event_in,
   // drop decision
   input  logic        pkt_valid_in,
   input  logic [1:0]  pkt_queue_in,
   input  logic [1:0]  pkt_colour_in,
   output logic        drop_valid_out,
   output logic        drop_out,
   // scheduler
   input  logic [2:0]  queue_count_in,
   input  logic [3:0]  q_ready_in,
   input  logic        pkt_sent_in,
   output logic        sel_valid_out,
   output logic [1:0]  sel_queue_out,
   output logic [7:0]  shaper_mode_out,
   // egress vlan id
   input  logic [11:0] port_default_vlan_id_in,
   input  logic        double_tag_in,
   input  logic [11:0] eg_vid_in,
   input  logic [11:0] eg_outer_provider_tag_in,
   output logic [11:0] eg_vid_out,
   output logic [11:0] eg_outer_provider_tag_out
);
   logic [10:0] pm_max_ff;
   logic [10:0] pm_min_ff;
   logic [10:0] pm_mult_ff;
   logic [10:0] q_max_ff    [NUM_Q];
   logic [10:0] q_min_ff    [NUM_Q];
   logic [10:0] q_mult_ff   [NUM_Q];
   logic [23:0] q_cnt_ff    [NUM_Q];
   logic [1:0]  sched_ff    [NUM_Q];
   logic [1:0]  shaper_ff   [NUM_Q];
   logic [6:0]  weight_ff   [NUM_Q];
   logic [10:0] q_avg       [NUM_Q];
   logic [27:0] weights;
   logic [5:0]  mon_ff;
   logic [1:0]  idx_ff;
   logic        repl_ff;
   logic [15:0] lfsr_ff;
   logic        aw_hold_ff;
   logic        w_hold_ff;
   logic [11:0] aw_addr_ff;
   logic [31:0] w_data_ff;
   logic [3:0]  w_strb_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic        wr_go;
   logic [31:0] wval;
   logic        flush_pulse;
   logic        drop_ff;
   logic        dvalid_ff;
   logic [11:0] vid_ff;
   logic [11:0] outer_ff;

   function automatic logic mapped(input logic [11:0] a);
      logic [11:0] w;
      w = {a[11:2], 2'b00};
      return (w == OFF_MEM_CTRL_0) || (w == OFF_MEM_CTRL_1) || (w == OFF_Q_CTRL_0) ||
             (w == OFF_Q_CTRL_1) || (w == OFF_MON_CTRL) || (w == OFF_Q_INDEX) ||
             (w == OFF_VID_REPL) || (w == OFF_TXQ_CTRL);
   endfunction : mapped

   function automatic logic [31:0] rd_mux(input logic [11:0] a);
      logic [31:0] r;
      r = '0;
      case ({a[11:2], 2'b00})
         OFF_MEM_CTRL_0: r = {5'h00, pm_max_ff, 5'h00, pm_min_ff};
         OFF_MEM_CTRL_1: r = {5'h00, pm_mult_ff, 5'h00, mem_avg_in};
         OFF_Q_CTRL_0:   r = {5'h00, q_max_ff[idx_ff], 5'h00, q_min_ff[idx_ff]};
         OFF_Q_CTRL_1:   r = {5'h00, q_mult_ff[idx_ff], 5'h00, q_avg[idx_ff]};
         OFF_MON_CTRL:   r = {mon_ff, 2'b00, q_cnt_ff[idx_ff]};
         // index mirrored in byte 3 so a byte read at 0x903 sees it
         OFF_Q_INDEX:    r = {6'h00, idx_ff, 22'h00_0000, idx_ff};
         OFF_VID_REPL:   r = {31'h0000_0000, repl_ff};
         OFF_TXQ_CTRL:   r = {17'h0_0000, weight_ff[idx_ff], sched_ff[idx_ff],
                              shaper_ff[idx_ff], 4'h0};
         default:        r = '0;
      endcase
      return r;
   endfunction : rd_mux

   // byte lanes not strobed keep their current contents
   always_comb begin
      wval = rd_mux(aw_addr_ff);
      for (int b = 0; b < 4; b++) begin
         if (w_strb_ff[b]) begin
            wval[b*8 +: 8] = w_data_ff[b*8 +: 8];
         end
      end
   end

   assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign awready_out = !aw_hold_ff && !bvalid_ff;
   assign wready_out = !w_hold_ff && !bvalid_ff;
   assign arready_out = !rvalid_ff;
   assign bvalid_out = bvalid_ff;
   assign bresp_out = bresp_ff;
   assign rvalid_out = rvalid_ff;
   assign rdata_out = rdata_ff;
   assign rresp_out = rresp_ff;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         aw_hold_ff <= 1'b0;
         aw_addr_ff <= 12'h000;
      end else if (awvalid_in && awready_out) begin
         aw_hold_ff <= 1'b1;
         aw_addr_ff <= awaddr_in;
      end else if (wr_go) begin
         aw_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         w_hold_ff <= 1'b0;
         w_data_ff <= '0;
         w_strb_ff <= 4'h0;
      end else if (wvalid_in && wready_out) begin
         w_hold_ff <= 1'b1;
         w_data_ff <= wdata_in;
         w_strb_ff <= wstrb_in;
      end else if (wr_go) begin
         w_hold_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff <= mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready_in) begin
         bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= RESP_OKAY;
      end else if (arvalid_in && arready_out) begin
         rvalid_ff <= 1'b1;
         rdata_ff <= rd_mux(araddr_in);
         rresp_ff <= mapped(araddr_in) ? RESP_OKAY : RESP_SLVERR;
      end else if (rready_in) begin
         rvalid_ff <= 1'b0;
      end
   end

   // port-wide registers
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pm_max_ff <= RST_PM_MAX;
         pm_min_ff <= RST_PM_MIN;
         pm_mult_ff <= RST_PM_MULT;
         mon_ff <= 6'h00;
         idx_ff <= 2'd0;
         repl_ff <= 1'b0;
      end else if (wr_go) begin
         case ({aw_addr_ff[11:2], 2'b00})
            OFF_MEM_CTRL_0: begin
               pm_max_ff <= wval[HI_LSB +: THR_W];
               pm_min_ff <= wval[THR_W-1:0];
            end
            OFF_MEM_CTRL_1: pm_mult_ff <= wval[HI_LSB +: THR_W];
            OFF_MON_CTRL:   mon_ff <= wval[31:26];
            OFF_Q_INDEX: begin
               // a lone byte-3 write is the 8-bit form of the index
               if (w_strb_ff == 4'h8) begin
                  idx_ff <= wval[IDX_B3_LSB +: 2];
               end else begin
                  idx_ff <= wval[1:0];
               end
            end
            OFF_VID_REPL:   repl_ff <= wval[0];
            default: begin
            end
         endcase
      end
   end

   assign flush_pulse = wr_go && ({aw_addr_ff[11:2], 2'b00} == OFF_MON_CTRL) &&
                        wval[MON_FLUSH] && !mon_ff[MON_FLUSH-26];

   for (genvar i = 0; i < NUM_Q; i++) begin : g_q
      logic sel_wr;
      assign sel_wr = wr_go && (idx_ff == 2'(i));
      assign q_avg[i] = q_avg_in[i*THR_W +: THR_W];
      assign weights[i*WGT_W +: WGT_W] = weight_ff[i];
      assign shaper_mode_out[i*2 +: 2] = shaper_ff[i];

      always_ff @(posedge clk_in) begin
         if (!rst_n_in) begin
            q_max_ff[i] <= RST_Q_MAX;
            q_min_ff[i] <= RST_Q_MIN;
            q_mult_ff[i] <= RST_Q_MULT;
            sched_ff[i] <= SCHED_WRR;
            shaper_ff[i] <= SHAPER_NONE;
            weight_ff[i] <= RST_WEIGHT;
         end else if (sel_wr) begin
            case ({aw_addr_ff[11:2], 2'b00})
               OFF_Q_CTRL_0: begin
                  q_max_ff[i] <= wval[HI_LSB +: THR_W];
                  q_min_ff[i] <= wval[THR_W-1:0];
               end
               OFF_Q_CTRL_1: q_mult_ff[i] <= wval[HI_LSB +: THR_W];
               OFF_TXQ_CTRL: begin
                  // reserved scheduler codes are refused, old mode stays
                  if (wval[SCHED_LSB +: 2] == SCHED_STRICT ||
                      wval[SCHED_LSB +: 2] == SCHED_WRR) begin
                     sched_ff[i] <= wval[SCHED_LSB +: 2];
                  end
                  shaper_ff[i] <= wval[SHAPER_LSB +: 2];
                  weight_ff[i] <= wval[WEIGHT_LSB +: WGT_W];
               end
               default: begin
               end
            endcase
         end
      end

      // a packet event in the flush cycle still counts
      always_ff @(posedge clk_in) begin
         if (!rst_n_in) begin
            q_cnt_ff[i] <= 24'h00_0000;
         end else if (flush_pulse) begin
            q_cnt_ff[i] <= {23'h00_0000, pkt_event_in[i]};
         end else if (pkt_event_in[i] && q_cnt_ff[i] != 24'hff_ffff) begin
            q_cnt_ff[i] <= 24'(q_cnt_ff[i] + 24'd1);
         end
      end
   end

   // drop decision, one cycle after the packet is offered
   logic [10:0] sel_avg;
   logic [10:0] sel_min;
   logic [10:0] sel_max;
   logic [21:0] q_prod;
   logic [21:0] pm_prod;
   logic        protect;
   logic        q_over;
   logic        q_rand;
   logic        pm_rand;
   logic        drop_now;

   assign sel_avg = q_avg[pkt_queue_in];
   assign sel_min = q_min_ff[pkt_queue_in];
   assign sel_max = q_max_ff[pkt_queue_in];
   assign protect = mon_ff[MON_ALL_COL-26] ||
                    (mon_ff[MON_YR-26] && pkt_colour_in != COL_GREEN) ||
                    (mon_ff[MON_R-26] && pkt_colour_in == COL_RED);
   assign q_over = sel_avg > sel_max;
   assign q_prod = 22'(11'(sel_avg - sel_min)) * 22'(q_mult_ff[pkt_queue_in]);
   assign pm_prod = 22'(11'(mem_avg_in - pm_min_ff)) * 22'(pm_mult_ff);
   assign q_rand = (sel_avg >= sel_min) && (q_prod[21:6] > lfsr_ff);
   assign pm_rand = (mem_avg_in >= pm_min_ff) && (pm_prod[21:6] > lfsr_ff);
   assign drop_now = mon_ff[MON_RDE-26] && !protect &&
                     ((q_over && mon_ff[MON_DROP_ALL-26]) || q_rand || pm_rand);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         lfsr_ff <= RST_LFSR;
      end else begin
         lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         drop_ff <= 1'b0;
         dvalid_ff <= 1'b0;
      end else begin
         dvalid_ff <= pkt_valid_in;
         drop_ff <= pkt_valid_in && drop_now;
      end
   end

   assign drop_valid_out = dvalid_ff;
   assign drop_out = drop_ff;

   // only the tag that carries the port id is rewritten
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         vid_ff <= 12'h000;
         outer_ff <= 12'h000;
      end else begin
         vid_ff <= eg_vid_in;
         outer_ff <= eg_outer_provider_tag_in;
         if (repl_ff && double_tag_in && eg_outer_provider_tag_in != 12'h000) begin
            outer_ff <= port_default_vlan_id_in;
         end
         if (repl_ff && !double_tag_in && eg_vid_in != 12'h000) begin
            vid_ff <= port_default_vlan_id_in;
         end
      end
   end

   assign eg_vid_out = vid_ff;
   assign eg_outer_provider_tag_out = outer_ff;

   // scheduler takes its mode from the queue-0 entry
   egress_sched u_sched (
      .clk_in         (clk_in),
      .rst_n_in       (rst_n_in),
      .sched_mode_in  (sched_ff[0]),
      .queue_count_in (queue_count_in),
      .weights_in     (weights),
      .q_ready_in     (q_ready_in),
      .pkt_sent_in    (pkt_sent_in),
      .sel_valid_out  (sel_valid_out),
      .sel_queue_out  (sel_queue_out)
   );

   sequence s_wr_taken;
      wr_go;
   endsequence

   a_resp_follows: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_wr_taken |=> bvalid_ff ##1 (bvalid_ff || !aw_hold_ff))
      else $error("write response missing");

   a_flush_clears: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (flush_pulse && !pkt_event_in[0]) |=> (q_cnt_ff[0] == 24'h00_0000))
      else $error("rising flush did not clear counter");

   a_flush_level: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (mon_ff[MON_FLUSH-26] && pkt_event_in[0] && q_cnt_ff[0] < 24'hff_fff0)
      |=> (q_cnt_ff[0] == 24'($past(q_cnt_ff[0]) + 24'd1)))
      else $error("steady flush level disturbed counter");

   a_drop_disabled: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !mon_ff[MON_RDE-26] |=> !drop_out)
      else $error("drop while random drop disabled");

   a_red_protect: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (pkt_colour_in == COL_RED && (mon_ff[MON_R-26] || mon_ff[MON_YR-26])) |=> !drop_out)
      else $error("protected red packet dropped");

   a_drop_all_max: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (pkt_valid_in && mon_ff[MON_RDE-26] && !protect && q_over && mon_ff[MON_DROP_ALL-26])
      |=> drop_out && drop_valid_out)
      else $error("drop all above maximum missed");

   a_below_min: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (sel_avg < sel_min && mem_avg_in < pm_min_ff && !(q_over && mon_ff[MON_DROP_ALL-26]))
      |=> !drop_out)
      else $error("drop below both minimum thresholds");

   a_vid_replace: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (repl_ff && !double_tag_in && eg_vid_in != 12'h000)
      |=> (eg_vid_out == $past(port_default_vlan_id_in)))
      else $error("egress vlan id not replaced");

   a_index_byte: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (wr_go && {aw_addr_ff[11:2], 2'b00} == OFF_Q_INDEX && w_strb_ff == 4'h8)
      |=> (idx_ff == $past(w_data_ff[25:24])))
      else $error("byte write of index lost");

   a_sched_reserved: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (wr_go && {aw_addr_ff[11:2], 2'b00} == OFF_TXQ_CTRL && wval[SCHED_LSB] && idx_ff == 2'd0)
      |=> $stable(sched_ff[0]))
      else $error("reserved scheduler mode accepted");
endmodule : port_wred_egress_queue_config

// [core/wred_egress_pkg.sv]
package wred_egress_pkg;
   localparam int unsigned NUM_Q = 4;
   localparam int unsigned THR_W = 11;
   localparam int unsigned CNT_W = 24;
   localparam int unsigned WGT_W = 7;

   // register byte offsets, one aligned word each
   localparam logic [11:0] OFF_MEM_CTRL_0 = 12'h830;
   localparam logic [11:0] OFF_MEM_CTRL_1 = 12'h834;
   localparam logic [11:0] OFF_Q_CTRL_0   = 12'h840;
   localparam logic [11:0] OFF_Q_CTRL_1   = 12'h844;
   localparam logic [11:0] OFF_MON_CTRL   = 12'h848;
   localparam logic [11:0] OFF_Q_INDEX    = 12'h900;
   localparam logic [11:0] OFF_VID_REPL   = 12'h904;
   localparam logic [11:0] OFF_TXQ_CTRL   = 12'h914;

   // field positions
   localparam int unsigned HI_LSB       = 16;
   localparam int unsigned MON_RDE      = 31;
   localparam int unsigned MON_FLUSH    = 30;
   localparam int unsigned MON_ALL_COL  = 29;
   localparam int unsigned MON_YR       = 28;
   localparam int unsigned MON_R        = 27;
   localparam int unsigned MON_DROP_ALL = 26;
   localparam int unsigned IDX_B3_LSB   = 24;
   localparam int unsigned SCHED_LSB    = 6;
   localparam int unsigned SHAPER_LSB   = 4;
   localparam int unsigned WEIGHT_LSB   = 8;

   // values after reset
   localparam logic [10:0] RST_PM_MAX  = 11'h400;
   localparam logic [10:0] RST_PM_MIN  = 11'h080;
   localparam logic [10:0] RST_PM_MULT = 11'h020;
   localparam logic [10:0] RST_Q_MAX   = 11'h080;
   localparam logic [10:0] RST_Q_MIN   = 11'h009;
   localparam logic [10:0] RST_Q_MULT  = 11'h010;
   localparam logic [6:0]  RST_WEIGHT  = 7'h01;
   localparam logic [15:0] RST_LFSR    = 16'hace1;

   // encodings
   localparam logic [1:0] SCHED_STRICT = 2'h0;
   localparam logic [1:0] SCHED_WRR    = 2'h2;
   localparam logic [1:0] SHAPER_NONE  = 2'h0;
   localparam logic [1:0] COL_GREEN    = 2'h0;
   localparam logic [1:0] COL_RED      = 2'h2;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage : wred_egress_pkg

// [core/egress_sched.sv]
`timescale 1ns/1ps
module egress_sched
   import wred_egress_pkg::*;
(
   // clock and reset
   input  logic        clk_in,
   input  logic        rst_n_in,
   // configuration
   input  logic [1:0]  sched_mode_in,
   input  logic [2:0]  queue_count_in,
   input  logic [27:0] weights_in,
   // queue state
   input  logic [3:0]  q_ready_in,
   input  logic        pkt_sent_in,
   // selection
   output logic        sel_valid_out,
   output logic [1:0]  sel_queue_out
);
   logic [3:0] mask;
   logic [3:0] active;
   logic       multi;
   logic [1:0] cur_ff;
   logic [6:0] cnt_ff;
   logic [6:0] wgt;
   logic       valid_ff;
   logic [1:0] hi_q;
   logic [1:0] rr_q;

   assign multi = (queue_count_in == 3'd2) || (queue_count_in == 3'd4);
   assign mask = (queue_count_in == 3'd4) ? 4'hf : ((queue_count_in == 3'd2) ? 4'h3 : 4'h1);
   assign active = q_ready_in & mask;
   assign wgt = weights_in[cur_ff*WGT_W +: WGT_W];

   always_comb begin
      hi_q = 2'd0;
      for (int k = 0; k < NUM_Q; k++) begin
         if (active[k]) begin
            hi_q = 2'(k);
         end
      end
   end

   // next queue in descending turn, wrapping from 0 to 3
   always_comb begin
      rr_q = cur_ff;
      for (int k = 3; k >= 1; k--) begin
         if (active[2'(cur_ff - 2'(k))]) begin
            rr_q = 2'(cur_ff - 2'(k));
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cur_ff <= 2'd0;
         cnt_ff <= 7'h00;
      end else if (!multi) begin
         cur_ff <= 2'd0;
         cnt_ff <= 7'h00;
      end else if (sched_mode_in == SCHED_STRICT) begin
         cur_ff <= hi_q;
         cnt_ff <= 7'h00;
      end else if (!active[cur_ff]) begin
         cur_ff <= rr_q;
         cnt_ff <= 7'h00;
      end else if (pkt_sent_in) begin
         // a zero weight is misuse; it behaves as one packet
         if (7'(cnt_ff + 7'd1) >= wgt) begin
            cur_ff <= rr_q;
            cnt_ff <= 7'h00;
         end else begin
            cnt_ff <= 7'(cnt_ff + 7'd1);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         valid_ff <= 1'b0;
      end else begin
         valid_ff <= |active;
      end
   end

   assign sel_valid_out = valid_ff;
   assign sel_queue_out = cur_ff;

   a_wrr_weight_cap: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (multi && sched_mode_in == SCHED_WRR && wgt != 7'h00) |-> (cnt_ff < wgt))
      else $error("wrr packet count reached weight");

   a_strict_highest: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (multi && sched_mode_in == SCHED_STRICT && active[3])
      |=> (cur_ff == 2'd3) || $changed(sched_mode_in) || $changed(queue_count_in))
      else $error("strict priority skipped queue 3");
endmodule : egress_sched

// [verification/port_wred_egress_queue_config_tb_top.sv]
`timescale 1ns/1ps
module port_wred_egress_queue_config_tb_top;
   import wred_egress_pkg::*;
   logic clk_in = 0, rst_n_in = 0, awvalid_in = 0, wvalid_in = 0, bready_in = 0;
   logic arvalid_in = 0, rready_in = 0, pkt_valid_in = 0, pkt_sent_in = 0, double_tag_in = 0;
   logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
   logic drop_valid_out, drop_out, sel_valid_out;
   logic [1:0] bresp_out, rresp_out, sel_queue_out, lr, pkt_queue_in = 0, pkt_colour_in = 0;
   logic [2:0] awprot_in = 0, arprot_in = 0, queue_count_in = 3'h4;
   logic [3:0] wstrb_in = 0, pkt_event_in = 0, q_ready_in = 0;
   logic [7:0] shaper_mode_out;
   logic [10:0] mem_avg_in = 0;
   logic [11:0] awaddr_in = 0, araddr_in = 0, eg_vid_in = 0, eg_outer_provider_tag_in = 0;
   logic [11:0] port_default_vlan_id_in = 12'h5a5, eg_vid_out, eg_outer_provider_tag_out;
   logic [31:0] wdata_in = 0, rdata_out, ld, rs = 32'habb0_abfe;
   logic [43:0] q_avg_in = 0;
   int failures, total_checks, cyc;

   port_wred_egress_queue_config u_port_wred_egress_queue_config (.*);

   always #20 clk_in = ~clk_in;

   // generous ceiling: the sequence needs well under a thousand cycles
   always @(posedge clk_in) begin
      cyc++;
      if (cyc > 5000) begin
         failures++;
         give_verdict();
      end
   end

   function automatic logic [31:0] rnd();
      rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
      return rs;
   endfunction : rnd

   function automatic logic [1:0] hi(input logic [3:0] m);
      return m[3] ? 2'h3 : m[2] ? 2'h2 : m[1] ? 2'h1 : 2'h0;
   endfunction : hi

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic give_verdict;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   // leading edge keeps a release and the next request in different time steps
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      logic ta, tw;
      ta = 0;
      tw = 0;
      @(posedge clk_in);
      awaddr_in <= a;
      wdata_in <= d;
      wstrb_in <= s;
      awvalid_in <= 1;
      wvalid_in <= 1;
      bready_in <= 1;
      while (!(ta && tw)) begin
         @(posedge clk_in);
         if (awready_out === 1'b1 && !ta) begin
            ta = 1;
            awvalid_in <= 0;
         end
         if (wready_out === 1'b1 && !tw) begin
            tw = 1;
            wvalid_in <= 0;
         end
      end
      do @(posedge clk_in); while (bvalid_out !== 1'b1);
      lr = bresp_out;
      bready_in <= 0;
   endtask : wr

   task automatic rd(input logic [11:0] a);
      @(posedge clk_in);
      araddr_in <= a;
      arvalid_in <= 1;
      rready_in <= 1;
      do @(posedge clk_in); while (arready_out !== 1'b1);
      arvalid_in <= 0;
      do @(posedge clk_in); while (rvalid_out !== 1'b1);
      lr = rresp_out;
      ld = rdata_out;
      rready_in <= 0;
   endtask : rd

   task automatic pk(input logic [1:0] c, input logic e);
      @(posedge clk_in);
      pkt_valid_in <= 1;
      pkt_colour_in <= c;
      @(posedge clk_in);
      pkt_valid_in <= 0;
      @(posedge clk_in);
      chk({drop_valid_out, drop_out}, {1'b1, e});
   endtask : pk

   task automatic vt(input logic [11:0] v, o, input logic t, input logic [11:0] ev, eo);
      @(posedge clk_in);
      eg_vid_in <= v;
      eg_outer_provider_tag_in <= o;
      double_tag_in <= t;
      repeat (2) @(posedge clk_in);
      chk({eg_vid_out, eg_outer_provider_tag_out}, {ev, eo});
   endtask : vt

   task automatic ev();
      @(posedge clk_in);
      pkt_event_in <= 4'h1;
      @(posedge clk_in);
      pkt_event_in <= 0;
   endtask : ev

   initial begin
      int q;
      logic [31:0] r;
      logic [10:0] qx [4], qn [4], qm [4];
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1;
      mem_avg_in <= 11'(rnd());
      q_avg_in <= {33'(rnd()), 11'h7ff};
      rd(OFF_MEM_CTRL_0); chk(ld, 32'h0400_0080);
      rd(OFF_MEM_CTRL_1); chk(ld, {16'h0020, 5'h0, mem_avg_in});
      rd(OFF_Q_CTRL_0); chk(ld, 32'h0080_0009);
      rd(OFF_Q_CTRL_1); chk(ld, 32'h0010_07ff);
      rd(OFF_MON_CTRL); chk(ld, 32'h0);
      rd(OFF_Q_INDEX); chk(ld, 32'h0);
      rd(OFF_VID_REPL); chk(ld, 32'h0);
      rd(OFF_TXQ_CTRL); chk(ld, 32'h0000_0180);
      $display("reset values done");
      wr(OFF_MON_CTRL, 32'h8400_0000); pk(COL_GREEN, 1);
      wr(OFF_MON_CTRL, 32'ha400_0000); pk(COL_GREEN, 0);
      wr(OFF_MON_CTRL, 32'h8c00_0000); pk(COL_RED, 0);
      pk(COL_GREEN, 1);
      wr(OFF_MON_CTRL, 32'h9400_0000); pk(2'h1, 0);
      wr(OFF_MON_CTRL, 32'h0400_0000); pk(COL_GREEN, 0);
      $display("drop decision done");
      wr(12'h850, 32'hffff_ffff); chk(lr, RESP_SLVERR);
      rd(12'h850); chk(lr, RESP_SLVERR);
      for (q = 0; q < 4; q++) begin
         wr(OFF_Q_INDEX, 32'(q) << 24, 4'h8);
         r = rnd();
         qx[q] = r[26:16];
         qn[q] = r[10:0];
         wr(OFF_Q_CTRL_0, r);
         r = rnd();
         qm[q] = r[26:16];
         wr(OFF_Q_CTRL_1, r);
      end
      for (q = 3; q >= 0; q--) begin
         wr(OFF_Q_INDEX, 32'(q));
         rd(OFF_Q_INDEX); chk(ld, (32'(q) << 24) | 32'(q));
         rd(OFF_Q_CTRL_0); chk(ld, {5'h0, qx[q], 5'h0, qn[q]});
         rd(OFF_Q_CTRL_1); chk(ld, {5'h0, qm[q], 5'h0, q_avg_in[11*q +: 11]});
      end
      $display("indexed registers done");
      wr(OFF_MON_CTRL, 32'h0);
      repeat (3) ev();
      rd(OFF_MON_CTRL); chk(ld, 32'h3);
      wr(OFF_MON_CTRL, 32'h4000_0000); rd(OFF_MON_CTRL); chk(ld, 32'h4000_0000);
      ev();
      wr(OFF_MON_CTRL, 32'h4000_0000); rd(OFF_MON_CTRL); chk(ld, 32'h4000_0001);
      $display("monitor counters done");
      wr(OFF_VID_REPL, 32'h1);
      vt(12'h123, 12'h456, 0, 12'h5a5, 12'h456);
      vt(12'h000, 12'h456, 0, 12'h000, 12'h456);
      vt(12'h123, 12'h456, 1, 12'h123, 12'h5a5);
      wr(OFF_VID_REPL, 32'h0); vt(12'h123, 12'h456, 0, 12'h123, 12'h456);
      $display("vlan replacement done");
      wr(OFF_TXQ_CTRL, 32'h0000_0150); rd(OFF_TXQ_CTRL); chk(ld, 32'h0000_0190);
      wr(OFF_TXQ_CTRL, 32'h0000_0110); rd(OFF_TXQ_CTRL); chk(ld, 32'h0000_0110);
      chk(32'(shaper_mode_out[1:0]), 32'h1);
      for (q = 0; q < 6; q++) begin
         r = rnd() | 32'h1;
         @(posedge clk_in);
         q_ready_in <= r[3:0];
         repeat (2) @(posedge clk_in);
         chk({sel_valid_out, sel_queue_out}, {1'b1, hi(r[3:0])});
      end
      $display("scheduler done");
      give_verdict();
   end
endmodule : port_wred_egress_queue_config_tb_top
